// *** src/fesb_pkg.sv ***
// package for the flash erase, suspend and bypass command sequencer
package fesb_pkg;

  // ****************************************************************
  // command words and offsets
  // ****************************************************************
  localparam logic [15:0] CMD_UNLOCK1 = 16'h00AA; // first unlock datum
  localparam logic [15:0] CMD_UNLOCK2 = 16'h0055; // second unlock datum
  localparam logic [15:0] CMD_SETUP = 16'h0080; // erase setup
  localparam logic [15:0] CMD_CHIPERASE = 16'h0010; // whole-array erase
  localparam logic [15:0] CMD_SUSPEND = 16'h00B0; // erase or program suspend
  localparam logic [15:0] CMD_RESUME = 16'h0030; // erase or program resume
  localparam logic [15:0] CMD_BYP_PROG = 16'h00A0; // bypass program setup
  localparam logic [15:0] CMD_BYP_RST1 = 16'h0090; // bypass exit, first
  localparam logic [15:0] CMD_BYP_RST2 = 16'h0000; // bypass exit, second
  localparam logic [15:0] CMD_ABORT_RST = 16'h00F0; // buffer abort reset
  localparam logic [11:0] OFS_UNLOCK1 = 12'h555; // bank-relative word offset
  localparam logic [11:0] OFS_UNLOCK2 = 12'h2AA; // bank-relative word offset
  localparam logic [11:0] OFS_ZERO = 12'h000; // bank base

  // ****************************************************************
  // field positions and timing
  // ****************************************************************
  localparam int POLL_BIT = 7; // completion_poll_bit position
  localparam int TOGGLE_BIT = 6; // toggle_status_bit position
  localparam int CLK_NS = 40; // 25 MHz clock period
  localparam int WR_PULSE_NS = 80; // least write strobe low time
  localparam int WR_PULSE_CYC = (WR_PULSE_NS + CLK_NS - 1) / CLK_NS; // rounded up
  localparam int MAX_ACCEL_USES = 10; // accelerated ops in total, one count over all banks

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [5:0] {
    OP_CHIP_ERASE = 6'h01, // six-write chip erase
    OP_SUSPEND = 6'h02, // single suspend write
    OP_RESUME = 6'h04, // single resume write
    OP_BYP_PROG = 6'h08, // two-write bypass program
    OP_BYP_EXIT = 6'h10, // two-write bypass exit
    OP_ABORT_RST = 6'h20 // three-write buffer abort reset, full unlock pair kept
  } fesb_op_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1, // waiting for a command
    ST_SETUP = 4'h2, // drive address and data
    ST_STROBE = 4'h4, // write strobe low
    ST_GAP = 4'h8 // strobe high, advance
  } fesb_state_t;

  typedef struct packed {
    fesb_op_t op; // requested operation
    logic [3:0] bank; // target bank
    logic [11:0] addr; // program address within bank
    logic [15:0] data; // program data
  } fesb_req_t;

  typedef struct packed {
    logic weN; // write strobe, active low
    logic ceN; // chip enable, active low
    logic [15:0] addr; // bank in high nibble, word offset low
    logic [15:0] dout; // data driven
    logic doe; // data output enable
    logic accel; // high voltage request on accel pin
  } fesb_bus_t;

  typedef struct packed {
    fesb_state_t st; // sequencer state
    logic [2:0] step; // write cycle index in the sequence
    logic [2:0] last; // index of final write
    logic [$clog2(WR_PULSE_CYC+1)-1:0] cnt; // strobe timer
    fesb_req_t req; // latched request
    fesb_bus_t bus; // registered pin values
    logic done; // one-cycle completion pulse
    logic [3:0] accelUses; // accelerated operations launched
  } fesb_reg_t;

endpackage : fesb_pkg

// *** src/fesb_host.sv ***
// host-side command sequencer driving the flash write pins
`timescale 1ns/1ps
`default_nettype none

module fesb_host
  import fesb_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // command port
  input wire logic reqValid,
  output logic reqReady,
  input wire fesb_req_t req,
  input wire logic accelEn,
  output logic opDone,
  output logic accelLimit,
  // flash write pins
  output logic flashWeN,
  output logic flashCeN,
  output logic [15:0] flashAddr,
  output logic [15:0] flashDqOut,
  output logic flashDqOe,
  output logic flashAccel
);

  // ****************************************************************
  // sequence table
  // ****************************************************************
  // chooses offset and datum of write number idx for an operation
  function automatic logic [27:0] seqWord(input fesb_op_t op, input logic [2:0] idx,
                                          input logic [11:0] pa, input logic [15:0] pd);
    logic [27:0] w;
    w = {OFS_ZERO, CMD_BYP_RST2};
    unique case (op)
      OP_CHIP_ERASE:
      begin
        unique case (idx)
          3'h0, 3'h3: w = {OFS_UNLOCK1, CMD_UNLOCK1};
          3'h1, 3'h4: w = {OFS_UNLOCK2, CMD_UNLOCK2};
          3'h2: w = {OFS_UNLOCK1, CMD_SETUP};
          default: w = {OFS_UNLOCK1, CMD_CHIPERASE};
        endcase
      end
      OP_SUSPEND: w = {OFS_ZERO, CMD_SUSPEND};
      OP_RESUME: w = {OFS_ZERO, CMD_RESUME};
      OP_BYP_PROG: w = (idx == 3'h0) ? {OFS_ZERO, CMD_BYP_PROG} : {pa, pd};
      OP_BYP_EXIT: w = (idx == 3'h0) ? {OFS_ZERO, CMD_BYP_RST1} : {OFS_ZERO, CMD_BYP_RST2};
      OP_ABORT_RST:
      begin
        // the unlock pair is never skipped, even in bypass mode
        unique case (idx)
          3'h0: w = {OFS_UNLOCK1, CMD_UNLOCK1};
          3'h1: w = {OFS_UNLOCK2, CMD_UNLOCK2};
          default: w = {OFS_UNLOCK1, CMD_ABORT_RST};
        endcase
      end
    endcase
    return w;
  endfunction

  // index of the final write for each operation
  function automatic logic [2:0] lastIdx(input fesb_op_t op);
    unique case (op)
      OP_CHIP_ERASE: return 3'h5;
      OP_SUSPEND, OP_RESUME: return 3'h0;
      OP_ABORT_RST: return 3'h2;
      default: return 3'h1;
    endcase
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  fesb_reg_t s_r; // all state
  fesb_reg_t s_nxt; // next state
  logic [27:0] word; // current offset and datum

  assign word = seqWord(s_r.req.op, s_r.step, s_r.req.addr, s_r.req.data);

  // next-state logic; one write cycle is setup, strobe low, strobe high
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.bus.accel = accelEn & ~accelLimit;
    unique case (s_r.st)
      ST_IDLE:
      begin
        // a lone idle cycle keeps writes apart on the pins
        if (reqValid)
        begin
          s_nxt.req = req;
          s_nxt.step = 3'h0;
          s_nxt.last = lastIdx(req.op);
          s_nxt.st = ST_SETUP;
          // each accelerated launch of erase or program counts against wear
          if (accelEn && !accelLimit && (req.op == OP_CHIP_ERASE || req.op == OP_BYP_PROG))
            s_nxt.accelUses = s_r.accelUses + 4'h1;
        end
      end
      ST_SETUP:
      begin
        // address and data settle before the strobe falls
        s_nxt.bus.ceN = 1'b0;
        s_nxt.bus.addr = {s_r.req.bank, word[27:16]};
        s_nxt.bus.dout = word[15:0];
        s_nxt.bus.doe = 1'b1;
        s_nxt.st = ST_STROBE;
        s_nxt.cnt = '0;
      end
      ST_STROBE:
      begin
        s_nxt.bus.weN = 1'b0;
        s_nxt.cnt = s_r.cnt + 1'b1;
        if (s_r.cnt == ($bits(s_r.cnt))'(WR_PULSE_CYC))
        begin
          s_nxt.bus.weN = 1'b1; // device latches data on this rising edge
          s_nxt.st = ST_GAP;
        end
      end
      ST_GAP:
      begin
        // release the bus between writes so no hold time is violated
        s_nxt.bus.ceN = 1'b1;
        s_nxt.bus.doe = 1'b0;
        if (s_r.step == s_r.last)
        begin
          s_nxt.st = ST_IDLE;
          s_nxt.done = 1'b1;
        end
        else
        begin
          s_nxt.step = s_r.step + 3'h1;
          s_nxt.st = ST_SETUP;
        end
      end
      default: s_nxt.st = ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_r <= '{st: ST_IDLE, step: 3'h0, last: 3'h0, cnt: '0,
               req: '{op: OP_SUSPEND, bank: 4'h0, addr: 12'h000, data: 16'h0000},
               bus: '{weN: 1'b1, ceN: 1'b1, addr: 16'h0000, dout: 16'h0000, doe: 1'b0, accel: 1'b0},
               done: 1'b0, accelUses: 4'h0};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign reqReady = (s_r.st == ST_IDLE);
  assign opDone = s_r.done;
  assign accelLimit = (s_r.accelUses >= 4'(MAX_ACCEL_USES));
  assign flashWeN = s_r.bus.weN;
  assign flashCeN = s_r.bus.ceN;
  assign flashAddr = s_r.bus.addr;
  assign flashDqOut = s_r.bus.dout;
  assign flashDqOe = s_r.bus.doe;
  assign flashAccel = s_r.bus.accel;

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_strobe_data: assert property (@(posedge clock) disable iff (!arst_n)
    !flashWeN |-> (flashDqOe && !flashCeN))
    else $error("strobe low without driven data");
  chk_erase_first: assert property (@(posedge clock) disable iff (!arst_n)
    ($fell(flashWeN) && s_r.req.op == OP_CHIP_ERASE && s_r.step == 3'h0)
      |-> (flashDqOut == CMD_UNLOCK1 && flashAddr[11:0] == OFS_UNLOCK1))
    else $error("chip erase does not open with unlock");
  chk_erase_last: assert property (@(posedge clock) disable iff (!arst_n)
    ($fell(flashWeN) && s_r.req.op == OP_CHIP_ERASE && s_r.step == 3'h5)
      |-> (flashDqOut == CMD_CHIPERASE))
    else $error("chip erase final datum wrong");
  chk_suspend_word: assert property (@(posedge clock) disable iff (!arst_n)
    ($fell(flashWeN) && s_r.req.op == OP_SUSPEND) |-> flashDqOut == CMD_SUSPEND)
    else $error("suspend datum wrong");
  chk_resume_word: assert property (@(posedge clock) disable iff (!arst_n)
    ($fell(flashWeN) && s_r.req.op == OP_RESUME) |-> flashDqOut == CMD_RESUME)
    else $error("resume datum wrong");
  chk_exit_pair: assert property (@(posedge clock) disable iff (!arst_n)
    ($fell(flashWeN) && s_r.req.op == OP_BYP_EXIT && s_r.step == 3'h1) |-> flashDqOut == CMD_BYP_RST2)
    else $error("bypass exit second datum wrong");
  chk_bypass_setup: assert property (@(posedge clock) disable iff (!arst_n)
    ($fell(flashWeN) && s_r.req.op == OP_BYP_PROG && s_r.step == 3'h0) |-> flashDqOut == CMD_BYP_PROG)
    else $error("bypass program setup wrong");
  chk_abort_last: assert property (@(posedge clock) disable iff (!arst_n)
    ($fell(flashWeN) && s_r.req.op == OP_ABORT_RST && s_r.step == 3'h2)
      |-> (flashDqOut == CMD_ABORT_RST && flashAddr[11:0] == OFS_UNLOCK1))
    else $error("abort reset final write wrong");
  chk_accel_cap: assert property (@(posedge clock) disable iff (!arst_n)
    accelLimit |=> !flashAccel)
    else $error("accel applied past wear cap");
  chk_done_count: assert property (@(posedge clock) disable iff (!arst_n)
    (reqValid && reqReady && req.op == OP_BYP_PROG) |-> ##11 opDone)
    else $error("bypass program not two writes");

endmodule // fesb_host

`default_nettype wire

// *** bench/fesb_flash_model.sv ***
// behavioural model of the banked flash command decoder seen by the host
`timescale 1ns/1ps
`default_nettype none

module fesb_flash_model
  import fesb_pkg::*;
(
  // write pins driven by the host
  input wire logic flashWeN,
  input wire logic flashCeN,
  input wire logic [15:0] flashAddr,
  input wire logic [15:0] flashDqOut,
  input wire logic flashDqOe,
  input wire logic flashAccel
);
  // ****************************************************************
  // device state
  // ****************************************************************
  logic [31:0] wlog [$]; // every latched write, address then data
  logic [1:0] unlk [16]; // unlock progress per bank
  logic susp [16]; // suspended flag per bank
  logic setup; // erase setup seen
  logic eraseAll; // whole-array erase running
  logic bypass; // unlock bypass mode
  logic bypPend; // next write is program data
  logic exitPend; // first exit write seen
  logic [3:0] bk; // bank of the current write
  logic [1:0] abt; // abort reset progress in bypass mode
  int aborts; // complete abort reset sequences accepted

  initial
  begin
    foreach (unlk[i])
    begin
      unlk[i] = 2'h0;
      susp[i] = 1'b0;
    end
    {setup, eraseAll, bypass, bypPend, exitPend} = 5'h00;
    abt = 2'h0;
    aborts = 0;
  end

  // decode on the rising strobe, which is where the device latches data
  always @(posedge flashWeN)
  begin
    if (!flashCeN && flashDqOe)
    begin
      bk = flashAddr[15:12];
      wlog.push_back({flashAddr, flashDqOut});
      if (flashAccel) bypass = 1'b1;
      if (bypPend) bypPend = 1'b0;
      else if (bypass)
      begin
        // anything but program, exit or the abort reset sequence is dropped in bypass
        if (flashDqOut == 16'h00A0) bypPend = 1'b1;
        else if (flashDqOut == 16'h0090) exitPend = 1'b1;
        else if (exitPend && flashDqOut == 16'h0000) {bypass, exitPend} = 2'h0;
        else if (flashDqOut == 16'h00AA && flashAddr[11:0] == 12'h555) abt = 2'h1;
        else if (abt == 2'h1 && flashDqOut == 16'h0055 && flashAddr[11:0] == 12'h2AA) abt = 2'h2;
        else
        begin
          // a lone abort datum without the unlock pair is not honoured
          if (abt == 2'h2 && flashDqOut == 16'h00F0 && flashAddr[11:0] == 12'h555) aborts++;
          abt = 2'h0;
        end
      end
      else if (flashDqOut == 16'h00B0 || flashDqOut == 16'h0030)
        susp[bk] = (flashDqOut == 16'h00B0) && !eraseAll;
      else if (flashDqOut == 16'h00AA && flashAddr[11:0] == 12'h555) unlk[bk] = 2'h1;
      else if (unlk[bk] == 2'h1 && flashDqOut == 16'h0055 && flashAddr[11:0] == 12'h2AA) unlk[bk] = 2'h2;
      else
      begin
        // erase setup and chip erase only count after a full unlock pair
        if (unlk[bk] == 2'h2 && flashDqOut == 16'h0080) setup = 1'b1;
        else if (unlk[bk] == 2'h2 && setup && flashDqOut == 16'h0010) eraseAll = 1'b1;
        unlk[bk] = 2'h0;
      end
    end
  end
endmodule // fesb_flash_model
`default_nettype wire

// *** bench/flash_erase_suspend_bypass_cmds_tb.sv ***
// self-checking testbench for the flash command sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samplesChecked++; if ((g) !== (e)) begin numErrors++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end

module flash_erase_suspend_bypass_cmds_tb import fesb_pkg::*;;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic clock, arst_n, reqValid, reqReady, accelEn, opDone, accelLimit;
  logic flashWeN, flashCeN, flashDqOe, flashAccel;
  logic [15:0] flashAddr, flashDqOut;
  fesb_req_t req; // command to the sequencer
  int numErrors = 0;
  int samplesChecked = 0;
  // chip erase writes as offset and datum
  localparam logic [27:0] CE [6] = '{28'h55500AA, 28'h2AA0055, 28'h5550080, 28'h55500AA, 28'h2AA0055, 28'h5550010};

  fesb_host dut (.clock, .arst_n, .reqValid, .reqReady, .req, .accelEn, .opDone, .accelLimit,
    .flashWeN, .flashCeN, .flashAddr, .flashDqOut, .flashDqOe, .flashAccel);
  fesb_flash_model model (.flashWeN, .flashCeN, .flashAddr, .flashDqOut, .flashDqOe, .flashAccel);

  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // expected write i of an operation, bank in the top nibble
  function automatic logic [31:0] expw(fesb_op_t op, logic [3:0] b, logic [11:0] a, logic [15:0] d, int i);
    case (op)
      OP_CHIP_ERASE: return {b, CE[i]};
      OP_SUSPEND: return {b, 28'h00000B0};
      OP_RESUME: return {b, 28'h0000030};
      OP_BYP_PROG: return (i == 0) ? {b, 28'h00000A0} : {b, a, d};
      OP_ABORT_RST: return (i < 2) ? {b, CE[i]} : {b, 28'h55500F0};
      default: return {b, 28'h0000000} | ((i == 0) ? 32'h00000090 : 32'h00000000);
    endcase
  endfunction

  task automatic conclude();
    $display("errors %0d checks %0d", numErrors, samplesChecked);
    if (numErrors == 0 && samplesChecked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // one request of n writes; timing and the latched writes are judged
  task automatic run(input fesb_op_t op, input logic [3:0] b, input logic [11:0] a, input logic [15:0] d, input int n);
    int cyc;
    int base;
    base = model.wlog.size();
    req = '{op: op, bank: b, addr: a, data: d};
    reqValid = 1'b1;
    cyc = 0;
    while (reqReady !== 1'b1 && cyc < 50)
    begin
      @(posedge clock);
      #1;
      cyc++;
    end
    if (cyc >= 50)
    begin
      numErrors++;
      conclude();
    end
    @(posedge clock);
    #1;
    reqValid = 1'b0;
    cyc = 0;
    do
    begin
      @(posedge clock);
      #1;
      cyc++;
    end while (opDone !== 1'b1 && cyc < 60);
    `CHK(cyc, 5 * n)
    `CHK(reqReady, 1'b1)
    if (cyc >= 60) conclude();
    `CHK(model.wlog.size() - base, n)
    for (int i = 0; i < n && base + i < model.wlog.size(); i++) `CHK(model.wlog[base + i], expw(op, b, a, d, i))
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic suspendResume();
    // back to back, offset forced to the bank base whatever addr holds
    for (int b = 5; b < 16; b += 10)
    begin
      run(OP_SUSPEND, 4'(b), 12'h7FF, 16'hFFFF, 1);
      `CHK(model.susp[b], 1'b1)
      run(OP_RESUME, 4'(b), 12'h7FF, 16'hFFFF, 1);
    end
  endtask

  task automatic bypassAccel();
    accelEn = 1'b1;
    @(posedge clock);
    #1;
    `CHK(flashAccel, 1'b1)
    for (int k = 0; k < 10; k++)
    begin
      `CHK(accelLimit, 1'b0)
      run(OP_BYP_PROG, 4'h2, 12'(k * 12'h111), 16'hA5C3 ^ 16'(k), 2);
    end
    `CHK(model.bypass, 1'b1)
    @(posedge clock);
    #1;
    `CHK({accelLimit, flashAccel}, 2'h2)
    run(OP_ABORT_RST, 4'h2, 12'h000, 16'h0000, 3);
    `CHK(model.aborts, 1)
    `CHK(model.bypass, 1'b1)
    accelEn = 1'b0;
    run(OP_BYP_EXIT, 4'h2, 12'h000, 16'h0000, 2);
    `CHK(model.bypass, 1'b0)
  endtask

  task automatic chipErase();
    run(OP_CHIP_ERASE, 4'h9, 12'h000, 16'h0000, 6);
    `CHK(model.eraseAll, 1'b1)
    run(OP_SUSPEND, 4'h9, 12'h000, 16'h0000, 1);
    `CHK(model.susp[9], 1'b0)
  endtask

  initial
  begin
    arst_n = 1'b0;
    reqValid = 1'b0;
    accelEn = 1'b0;
    req = '0;
    repeat (4) @(posedge clock);
    #1;
    // pins idle and ready while reset is held
    `CHK({flashWeN, flashCeN, flashDqOe, flashAccel, opDone, reqReady, flashAddr}, {6'h31, 16'h0000})
    arst_n = 1'b1;
    suspendResume();
    bypassAccel();
    chipErase();
    conclude();
  end
endmodule // flash_erase_suspend_bypass_cmds_tb
`default_nettype wire
